// ### hw/pmr_top.sv
// Register file, port routing and arbitration for the PHY management ports of four LAN ports.
// Assumes the EEPROM init words are settled while SRST is high; LINK_CLK runs free.
`timescale 1ns/100ps
`include "pmr_defines.svh"
module pmr_top (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic LINK_CLK,
   input wire logic [1:0] REG_LAN,
   input wire logic [15:0] REG_ADDR,
   input wire logic REG_WE,
   input wire logic REG_RE,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic [63:0] EE_INIT_CTRL3,
   output logic [1:0] MGMT_PIN_EN,
   output logic [1:0] MGMT_CLK_O,
   output logic [1:0] MGMT_CLK_OE,
   input wire logic [1:0] MGMT_DATA_I,
   output logic [1:0] MGMT_DATA_O,
   output logic [1:0] MGMT_DATA_OE
);
   logic [31:0] ext_q [`PMR_NUM_LAN];
   logic [31:0] ctl_q [`PMR_NUM_LAN];
   logic [31:0] cfg_q [`PMR_NUM_LAN];
   logic [31:0] tw_q [`PMR_NUM_LAN];
   logic [1:0] pend_q [`PMR_NUM_LAN];
   logic [3:0] share_w;
   logic [1:0] pin_en_w;
   pmr_pkg::pmr_route_t route_w [`PMR_NUM_LAN];
   logic [3:0] held_w;
   logic [1:0] cpl_v;
   logic [1:0] cpl_lan [2];
   logic [1:0] cpl_tw;
   logic [1:0] cpl_err;
   logic [15:0] cpl_data [2];
   logic [3:0] held_p [2];

   // Share bit 0 means dedicated, 1 shared
   // Each LAN has its own copy of every register
   always_comb begin
      for (int i = 0; i < `PMR_NUM_LAN; i++) begin
         share_w[i] = cfg_q[i][`PMR_CFG_SHARE];
      end
   end

   // Port zero is enabled by LAN 0 registers, port one by LAN 1 registers
   assign pin_en_w[0] = ext_q[0][`PMR_EXT_I2C_EN] && cfg_q[0][`PMR_CFG_DEST];
   assign pin_en_w[1] = ext_q[1][`PMR_EXT_I2C_EN] && cfg_q[1][`PMR_CFG_DEST];
   assign MGMT_PIN_EN = pin_en_w;

   function automatic pmr_pkg::pmr_route_t route_of(input logic [1:0] lan,
                                                     input logic [3:0] share,
                                                     input logic [1:0] en);
      pmr_pkg::pmr_route_t p0;
      p0 = en[0] ? pmr_pkg::ROUTE_PORT0 : pmr_pkg::ROUTE_NONE;
      if (lan == 2'h0) begin
         route_of = p0;
      end else if (lan == 2'h1) begin
         // Port one never serves anyone but LAN 1
         route_of = (share[0] && share[1]) ? p0
                  : (en[1] ? pmr_pkg::ROUTE_PORT1 : pmr_pkg::ROUTE_NONE);
      end else begin
         route_of = (share[lan] && share[0]) ? p0 : pmr_pkg::ROUTE_NONE;
      end
   endfunction

   // Clause 22 frame: preamble, start, op, addresses, turnaround, data
   function automatic pmr_pkg::pmr_frame_t mdio_frame(input logic [31:0] c);
      logic rd;
      rd = (c[27:26] == `PMR_OP_READ);
      mdio_frame.bits = {32'hFFFFFFFF, `PMR_MDIO_ST, c[27:26], c[25:21], c[20:16],
                         `PMR_TA_WRITE, c[15:0]};
      mdio_frame.drive = rd ? {46'h3FFFFFFFFFFF, 18'h00000} : 64'hFFFFFFFFFFFFFFFF;
      mdio_frame.nbits = `PMR_MDIO_BITS;
   endfunction

   // Two-wire frame, left aligned; released slots are the target's acks and read data
   function automatic pmr_pkg::pmr_frame_t tw_frame(input logic [31:0] c);
      logic [6:0] dev;
      dev = {`PMR_TW_DEV_HI, c[26:24]};
      if (c[`PMR_TW_RD]) begin
         tw_frame.bits = {dev, 1'b1, 1'b1, 8'hFF, 1'b0, 8'hFF, 1'b1, 37'h0};
         tw_frame.drive = {8'hFF, 1'b0, 8'h00, 1'b1, 8'h00, 1'b1, 37'h0};
         tw_frame.nbits = `PMR_TW_RD_BITS;
      end else begin
         tw_frame.bits = {dev, 1'b0, 1'b1, c[23:16], 1'b1, c[15:8], 1'b1, c[7:0], 1'b1, 28'h0};
         tw_frame.drive = {8'hFF, 1'b0, 8'hFF, 1'b0, 8'hFF, 1'b0, 8'hFF, 1'b0, 28'h0};
         tw_frame.nbits = `PMR_TW_WR_BITS;
      end
   endfunction

   always_comb begin
      for (int i = 0; i < `PMR_NUM_LAN; i++) begin
         route_w[i] = route_of(2'(i), share_w, pin_en_w);
         held_w[i] = held_p[0][i] || held_p[1][i];
      end
   end

   // One set of registers for each LAN port
   generate
      for (genvar l = 0; l < `PMR_NUM_LAN; l++) begin : g_lan
         logic wr;
         logic orphan;
         assign wr = REG_WE && (REG_LAN == 2'(l));
         // A pending access whose route vanished and is not on a link ends with an error
         assign orphan = (route_w[l] == pmr_pkg::ROUTE_NONE) && !held_w[l];

         always_ff @(posedge CLK) begin
            if (SRST) begin
               ext_q[l] <= `PMR_EXT_RESET;
               // Destination and share bits come from the EEPROM init word
               cfg_q[l] <= {EE_INIT_CTRL3[16*l+`PMR_EE_DEST],
                            EE_INIT_CTRL3[16*l+`PMR_EE_SHARE], 30'h0};
            end else if (wr) begin
               if (REG_ADDR == `PMR_OFF_EXT_CTRL) begin
                  ext_q[l] <= REG_WDATA;
               end
               if (REG_ADDR == `PMR_OFF_MGMT_CFG) begin
                  cfg_q[l] <= REG_WDATA & `PMR_CFG_WMASK;
               end
            end
         end

         always_ff @(posedge CLK) begin
            if (SRST) begin
               ctl_q[l] <= `PMR_CTL_RESET;
               tw_q[l] <= `PMR_TW_RESET;
               pend_q[l] <= 2'h0;
            end else begin
               for (int p = 0; p < 2; p++) begin
                  if (cpl_v[p] && cpl_lan[p] == 2'(l)) begin
                     if (cpl_tw[p]) begin
                        tw_q[l][15:0] <= cpl_data[p];
                        tw_q[l][`PMR_TW_ERR] <= cpl_err[p];
                        tw_q[l][`PMR_TW_READY] <= 1'b1;
                        pend_q[l][1] <= 1'b0;
                     end else begin
                        ctl_q[l][15:0] <= cpl_data[p];
                        ctl_q[l][`PMR_CTL_ERR] <= cpl_err[p];
                        ctl_q[l][`PMR_CTL_READY] <= 1'b1;
                        pend_q[l][0] <= 1'b0;
                     end
                  end
               end
               if (orphan && pend_q[l][0]) begin
                  ctl_q[l][`PMR_CTL_ERR] <= 1'b1;
                  ctl_q[l][`PMR_CTL_READY] <= 1'b1;
                  pend_q[l][0] <= 1'b0;
               end
               if (orphan && pend_q[l][1]) begin
                  tw_q[l][`PMR_TW_ERR] <= 1'b1;
                  tw_q[l][`PMR_TW_READY] <= 1'b1;
                  pend_q[l][1] <= 1'b0;
               end
               // A new command while one is pending is ignored, so no set meets a clear
               if (wr && REG_ADDR == `PMR_OFF_MGMT_CTRL && !pend_q[l][0]) begin
                  ctl_q[l] <= REG_WDATA & `PMR_CTL_WMASK;
                  if (REG_WDATA[27:26] == `PMR_OP_WRITE || REG_WDATA[27:26] == `PMR_OP_READ) begin
                     pend_q[l][0] <= 1'b1;
                  end else begin
                     // Clause 45 address frames are not offered
                     ctl_q[l][`PMR_CTL_ERR] <= 1'b1;
                     ctl_q[l][`PMR_CTL_READY] <= 1'b1;
                  end
               end
               if (wr && REG_ADDR == `PMR_OFF_TW_CMD && !pend_q[l][1]) begin
                  tw_q[l] <= REG_WDATA & `PMR_TW_WMASK;
                  pend_q[l][1] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // One arbiter and engine per physical management port
   generate
      for (genvar p = 0; p < 2; p++) begin : g_port
         pmr_link_if lk ();
         pmr_pkg::pmr_cstate_t st_q;
         logic [1:0] gnt_q;
         logic kind_q, req_q, en_q;
         logic s1, s2, s3;
         pmr_pkg::pmr_frame_t frame_q;
         logic [3:0] want;
         logic [1:0] pick;
         logic found;
         logic [63:0] sm;
         logic rd;

         assign lk.req_tgl = req_q;
         assign lk.twowire = kind_q;
         assign lk.frame = frame_q;
         assign lk.en = en_q;
         assign sm = lk.samp;
         assign held_p[p] = (st_q == pmr_pkg::C_BUSY) ? 4'(1) << gnt_q : 4'h0;
         assign rd = kind_q ? tw_q[gnt_q][`PMR_TW_RD] : (ctl_q[gnt_q][27:26] == `PMR_OP_READ);

         // Lowest-numbered requesting LAN port wins the shared port
         always_comb begin
            found = 1'b0;
            pick = 2'h0;
            for (int i = 0; i < `PMR_NUM_LAN; i++) begin
               want[i] = (|pend_q[i]) &&
                         (route_w[i] == (p == 0 ? pmr_pkg::ROUTE_PORT0 : pmr_pkg::ROUTE_PORT1));
            end
            for (int i = `PMR_NUM_LAN - 1; i >= 0; i--) begin
               if (want[i]) begin
                  found = 1'b1;
                  pick = 2'(i);
               end
            end
         end

         // Done toggle crosses from the link clock through two flops
         always_ff @(posedge CLK) begin
            s1 <= lk.done_tgl;
            s2 <= s1;
            s3 <= s2;
         end

         always_ff @(posedge CLK) begin
            if (SRST) begin
               en_q <= 1'b0;
            end else begin
               en_q <= pin_en_w[p];
            end
         end

         always_ff @(posedge CLK) begin
            if (SRST) begin
               st_q <= pmr_pkg::C_IDLE;
               gnt_q <= 2'h0;
               kind_q <= 1'b0;
               req_q <= 1'b0;
               frame_q <= '0;
               cpl_v[p] <= 1'b0;
               cpl_tw[p] <= 1'b0;
               cpl_err[p] <= 1'b0;
               cpl_data[p] <= 16'h0000;
            end else begin
               cpl_v[p] <= 1'b0;
               unique case (st_q)
                  pmr_pkg::C_IDLE: begin
                     if (found && !cpl_v[p]) begin
                        gnt_q <= pick;
                        kind_q <= !pend_q[pick][0];
                        frame_q <= pend_q[pick][0] ? mdio_frame(ctl_q[pick])
                                                   : tw_frame(tw_q[pick]);
                        req_q <= ~req_q;
                        st_q <= pmr_pkg::C_BUSY;
                     end
                  end
                  pmr_pkg::C_BUSY: begin
                     // Grant is held until the engine reports the frame finished
                     if (s2 ^ s3) begin
                        cpl_v[p] <= 1'b1;
                        cpl_tw[p] <= kind_q;
                        if (kind_q) begin
                           cpl_data[p] <= rd ? {sm[17:10], sm[8:1]} : tw_q[gnt_q][15:0];
                           cpl_err[p] <= rd ? sm[18] : (sm[0] | sm[9] | sm[18] | sm[27]);
                        end else begin
                           cpl_data[p] <= rd ? sm[15:0] : ctl_q[gnt_q][15:0];
                           cpl_err[p] <= 1'b0;
                        end
                        st_q <= pmr_pkg::C_IDLE;
                     end
                  end
               endcase
            end
         end
         assign cpl_lan[p] = gnt_q;

         pmr_engine u_eng (
            .lclk(LINK_CLK),
            .srst(SRST),
            .lk(lk.eng),
            .data_i(MGMT_DATA_I[p]),
            .clk_o(MGMT_CLK_O[p]),
            .clk_oe(MGMT_CLK_OE[p]),
            .data_o(MGMT_DATA_O[p]),
            .data_oe(MGMT_DATA_OE[p])
         );
      end
   endgenerate

   // Register reads answer one cycle later; unmapped offsets read zero
   // Data holds until the next read, so an idle port never shows fresh values
   always_ff @(posedge CLK) begin
      if (SRST) begin
         REG_RDATA <= 32'h00000000;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RE;
         if (REG_RE) begin
            unique case (REG_ADDR)
               `PMR_OFF_EXT_CTRL: REG_RDATA <= ext_q[REG_LAN];
               `PMR_OFF_MGMT_CTRL: REG_RDATA <= ctl_q[REG_LAN];
               `PMR_OFF_MGMT_CFG: REG_RDATA <= cfg_q[REG_LAN];
               `PMR_OFF_TW_CMD: REG_RDATA <= tw_q[REG_LAN];
               default: REG_RDATA <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// ### hw/pmr_defines.svh
// Constants of the PHY management port routing block: offsets, fields, reset values, timing.
// Assumes byte addresses on the register port and a 50 MHz core clock.
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH
`define PMR_NUM_LAN 4
`define PMR_OFF_EXT_CTRL 16'h0018
`define PMR_OFF_MGMT_CTRL 16'h0020
`define PMR_OFF_MGMT_CFG 16'h0E04
`define PMR_OFF_TW_CMD 16'h1028
`define PMR_EXT_I2C_EN 25
`define PMR_CFG_DEST 31
`define PMR_CFG_SHARE 30
`define PMR_EE_DEST 2
`define PMR_EE_SHARE 3
`define PMR_CTL_READY 28
`define PMR_CTL_ERR 30
`define PMR_CTL_WMASK 32'h0FFFFFFF
`define PMR_CTL_RESET 32'h10000000
`define PMR_TW_READY 29
`define PMR_TW_ERR 31
`define PMR_TW_RD 27
`define PMR_TW_WMASK 32'h0FFFFFFF
`define PMR_TW_RESET 32'h20000000
`define PMR_EXT_RESET 32'h00000000
`define PMR_CFG_WMASK 32'hC0000000
`define PMR_TW_DEV_HI 4'h5
`define PMR_MDIO_ST 2'h1
`define PMR_OP_WRITE 2'h1
`define PMR_OP_READ 2'h2
`define PMR_TA_WRITE 2'h2
`define PMR_MDIO_BITS 7'h40
`define PMR_TW_WR_BITS 7'h24
`define PMR_TW_RD_BITS 7'h1B
`define PMR_LINK_NS 15
`define PMR_MDC_HALF_NS 200
`define PMR_SCL_HALF_NS 5000
`define PMR_MDC_HALF_CYC ((`PMR_MDC_HALF_NS + `PMR_LINK_NS - 1) / `PMR_LINK_NS)
`define PMR_SCL_HALF_CYC ((`PMR_SCL_HALF_NS + `PMR_LINK_NS - 1) / `PMR_LINK_NS)
`endif

// ### hw/pmr_pkg.sv
// Types shared by the routing core, the link interface and the serial engine.
// Assumes pmr_defines.svh supplies all numbers.
package pmr_pkg;
   typedef enum logic [2:0] {
      ROUTE_NONE = 3'h1,
      ROUTE_PORT0 = 3'h2,
      ROUTE_PORT1 = 3'h4
   } pmr_route_t;
   typedef enum logic [1:0] {
      C_IDLE = 2'h1,
      C_BUSY = 2'h2
   } pmr_cstate_t;
   typedef enum logic [4:0] {
      E_IDLE = 5'h01,
      E_START = 5'h02,
      E_LOW = 5'h04,
      E_HIGH = 5'h08,
      E_STOP = 5'h10
   } pmr_estate_t;
   typedef struct packed {
      logic [63:0] bits;
      logic [63:0] drive;
      logic [6:0] nbits;
   } pmr_frame_t;
endpackage

// ### hw/pmr_link_if.sv
// Carrier between the core-domain arbiter and one link-domain serial engine.
// Frame and kind are held stable by the core while a request toggle is in flight; enable follows the register every cycle.
`timescale 1ns/100ps
interface pmr_link_if;
   logic req_tgl;
   logic twowire;
   logic en;
   pmr_pkg::pmr_frame_t frame;
   logic done_tgl;
   logic [63:0] samp;
   modport core (output req_tgl, twowire, en, frame, input done_tgl, samp);
   modport eng (input req_tgl, twowire, en, frame, output done_tgl, samp);
endinterface

// ### hw/pmr_engine.sv
// Serial engine for one physical management port, running on the link clock.
// Assumes the core holds frame data steady from a request toggle until the done toggle.
`timescale 1ns/100ps
`include "pmr_defines.svh"
module pmr_engine (
   input wire logic lclk,
   input wire logic srst,
   pmr_link_if.eng lk,
   input wire logic data_i,
   output logic clk_o,
   output logic clk_oe,
   output logic data_o,
   output logic data_oe
);
   logic rs1, rs2, q1, q2, q3, en1, en2, d1, d2;
   pmr_pkg::pmr_estate_t st_q;
   logic [8:0] div_q;
   logic [6:0] cnt_q;
   logic [63:0] bits_q, drv_q, samp_q;
   logic tw_q, clk_q, dat_q, stop_q, done_q;
   logic tick;

   // Reset, request, enable and pin each pass two flops before use
   always_ff @(posedge lclk) begin
      rs1 <= srst;
      rs2 <= rs1;
      q1 <= lk.req_tgl;
      q2 <= q1;
      q3 <= q2;
      en1 <= lk.en;
      en2 <= en1;
      d1 <= data_i;
      d2 <= d1;
   end

   assign tick = (div_q == 9'h000);
   assign lk.done_tgl = done_q;
   assign lk.samp = samp_q;

   always_ff @(posedge lclk) begin
      if (rs2) begin
         st_q <= pmr_pkg::E_IDLE;
         div_q <= 9'h000;
         cnt_q <= 7'h00;
         bits_q <= 64'h0;
         drv_q <= 64'h0;
         samp_q <= 64'h0;
         tw_q <= 1'b0;
         clk_q <= 1'b1;
         dat_q <= 1'b1;
         stop_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         div_q <= tick ? (tw_q ? 9'(`PMR_SCL_HALF_CYC - 1) : 9'(`PMR_MDC_HALF_CYC - 1))
                       : div_q - 9'h001;
         unique case (st_q)
            pmr_pkg::E_IDLE: begin
               if (q2 ^ q3) begin
                  bits_q <= lk.frame.bits;
                  drv_q <= lk.frame.drive;
                  cnt_q <= lk.frame.nbits;
                  tw_q <= lk.twowire;
                  div_q <= lk.twowire ? 9'(`PMR_SCL_HALF_CYC - 1) : 9'(`PMR_MDC_HALF_CYC - 1);
                  // Two-wire start: data falls while the clock is still high
                  if (lk.twowire) begin
                     dat_q <= 1'b0;
                     st_q <= pmr_pkg::E_START;
                  end else begin
                     clk_q <= 1'b0;
                     dat_q <= lk.frame.drive[63] ? lk.frame.bits[63] : 1'b1;
                     st_q <= pmr_pkg::E_LOW;
                  end
               end
            end
            pmr_pkg::E_START: begin
               if (tick) begin
                  clk_q <= 1'b0;
                  dat_q <= drv_q[63] ? bits_q[63] : 1'b1;
                  st_q <= pmr_pkg::E_LOW;
               end
            end
            pmr_pkg::E_LOW: begin
               if (tick) begin
                  clk_q <= 1'b1;
                  st_q <= pmr_pkg::E_HIGH;
               end
            end
            pmr_pkg::E_HIGH: begin
               if (tick) begin
                  samp_q <= {samp_q[62:0], d2};
                  cnt_q <= cnt_q - 7'h01;
                  clk_q <= 1'b0;
                  bits_q <= {bits_q[62:0], 1'b0};
                  drv_q <= {drv_q[62:0], 1'b0};
                  if (cnt_q == 7'h01) begin
                     if (tw_q) begin
                        dat_q <= 1'b0;
                        stop_q <= 1'b0;
                        st_q <= pmr_pkg::E_STOP;
                     end else begin
                        clk_q <= 1'b1;
                        dat_q <= 1'b1;
                        done_q <= ~done_q;
                        st_q <= pmr_pkg::E_IDLE;
                     end
                  end else begin
                     dat_q <= drv_q[62] ? bits_q[62] : 1'b1;
                     st_q <= pmr_pkg::E_LOW;
                  end
               end
            end
            pmr_pkg::E_STOP: begin
               // Stop: clock rises first, data rises a half period later
               if (tick) begin
                  if (!stop_q) begin
                     clk_q <= 1'b1;
                     stop_q <= 1'b1;
                  end else begin
                     dat_q <= 1'b1;
                     done_q <= ~done_q;
                     st_q <= pmr_pkg::E_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Open drain: only ever pull low, and only while the port is enabled
   always_ff @(posedge lclk) begin
      if (rs2) begin
         clk_oe <= 1'b0;
         data_oe <= 1'b0;
         clk_o <= 1'b0;
         data_o <= 1'b0;
      end else begin
         clk_oe <= en2 && !clk_q;
         data_oe <= en2 && !dat_q;
         clk_o <= 1'b0;
         data_o <= 1'b0;
      end
   end
endmodule

// ### testbench/pmr_checker.sv
// Port-level assertions for the PHY management routing block.
// Assumes binding to pmr_top; core clock with synchronous reset.
`timescale 1ns/100ps
module pmr_checker (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [15:0] REG_ADDR,
   input wire logic REG_RE,
   input wire logic [31:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire logic [1:0] MGMT_PIN_EN,
   input wire logic [1:0] MGMT_CLK_O,
   input wire logic [1:0] MGMT_CLK_OE,
   input wire logic [1:0] MGMT_DATA_O,
   input wire logic [1:0] MGMT_DATA_OE
);
   logic hit;
   assign hit = REG_ADDR inside {16'h0018, 16'h0020, 16'h0E04, 16'h1028};
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (SRST);
   a_read_answer: assert property (REG_RE |=> REG_RVALID)
      else $error("read not answered");
   a_no_stray: assert property (!REG_RE |=> !REG_RVALID && $stable(REG_RDATA))
      else $error("stray read data");
   a_unmapped_zero: assert property (REG_RE && !hit |=> REG_RDATA == 32'h0)
      else $error("unmapped read not zero");
   a_cfg_fields: assert property (REG_RE && REG_ADDR == 16'h0E04
      |=> REG_RDATA[29:0] == 30'h0) else $error("config holds stray bits");
   // Six cycles cover the enable crossing into the link domain
   a_gate_zero: assert property ((!MGMT_PIN_EN[0]) [*6] |-> !(MGMT_CLK_OE[0] | MGMT_DATA_OE[0]))
      else $error("port zero pins move while disabled");
   a_gate_one: assert property ((!MGMT_PIN_EN[1]) [*6] |-> !(MGMT_CLK_OE[1] | MGMT_DATA_OE[1]))
      else $error("port one pins move while disabled");
   a_open_drain: assert property (MGMT_CLK_O == 2'h0 && MGMT_DATA_O == 2'h0)
      else $error("pin driven high");
   a_reset_quiet: assert property ($fell(SRST) |-> !REG_RVALID && MGMT_PIN_EN == 2'h0)
      else $error("outputs busy after reset");
   c_cmd: cover property (REG_RE && REG_ADDR == 16'h0020);
   c_port0: cover property ($rose(MGMT_CLK_OE[0]));
   c_port1: cover property ($rose(MGMT_CLK_OE[1]));
endmodule
bind pmr_top pmr_checker u_chk (.CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_RE(REG_RE),
   .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .MGMT_PIN_EN(MGMT_PIN_EN),
   .MGMT_CLK_O(MGMT_CLK_O), .MGMT_CLK_OE(MGMT_CLK_OE), .MGMT_DATA_O(MGMT_DATA_O),
   .MGMT_DATA_OE(MGMT_DATA_OE));

// ### testbench/pmr_phy_model.sv
// Behavioural PHY on one open-drain management port, MDIO or two-wire.
// Assumes the bench resolves wire levels; pull high means pull data low.
`timescale 1ns/100ps
module pmr_phy_model (
   input wire logic clk_lvl,
   input wire logic dat_lvl,
   input wire logic i2c,
   input wire logic [15:0] rd_val,
   output logic pull
);
   int k = 0;
   logic [1:0] sh = 2'h0;
   logic rdop = 1'b0;
   logic run = 1'b0;
   initial pull = 1'b0;
   always @(i2c) k = 0;
   // Two-wire frame opens with data falling while the clock is released
   // Look a moment later: data may fall in the same step as the clock
   always @(negedge dat_lvl) #1 if (i2c && clk_lvl) k = 0;
   // Count only once the clock was low, so its rise out of reset is no bit
   always @(posedge clk_lvl) if (run) begin
      sh = {sh[0], dat_lvl};
      k++;
      if (k == (i2c ? 8 : 36)) rdop = i2c ? dat_lvl : sh == 2'b10;
      // MDIO frames are always 64 bits; release after the last bit is sampled
      if (!i2c && k == 64) begin
         pull <= #400 1'b0;
         k = 0;
      end
   end
   // Change data only while the clock is low
   always @(negedge clk_lvl) begin
      run = 1'b1;
      if (i2c)
         pull = k == 8 || (!rdop && k < 36 && k % 9 == 8) ||
            (rdop && k > 8 && k < 17 && !rd_val[24 - k]) ||
            (rdop && k > 17 && k < 26 && !rd_val[25 - k]);
      else
         pull = rdop && k > 46 && k < 64 && (k == 47 || !rd_val[63 - k]);
   end
endmodule

// ### testbench/phy_mgmt_port_routing_tb.sv
// Self-checking bench for the PHY management routing block with two PHY models.
// Assumes design files compiled first; expectations are worked out here.
`timescale 1ns/100ps
module phy_mgmt_port_routing_tb;
   logic CLK = 1'b0, SRST = 1'b1, LINK_CLK = 1'b0, REG_WE = 1'b0, REG_RE = 1'b0, REG_RVALID;
   logic [1:0] REG_LAN = 2'h0, i2c = 2'h0;
   logic [15:0] REG_ADDR = 16'h0, w;
   logic [15:0] rv [2];
   logic [31:0] REG_WDATA = 32'h0, REG_RDATA, rd;
   logic [63:0] EE_INIT_CTRL3 = 64'h0000_0008_0004_000C;
   logic [1:0] MGMT_PIN_EN, MGMT_CLK_O, MGMT_CLK_OE, MGMT_DATA_O, MGMT_DATA_OE, pull, dat;
   logic [63:0] q [$];
   int err_total = 0, n_compared = 0, seed = 32'hDEA9;
   int n_act [2] = '{0, 0};
   assign dat = ~(MGMT_DATA_OE | pull);
   pmr_top u_dut (.CLK(CLK), .SRST(SRST), .LINK_CLK(LINK_CLK), .REG_LAN(REG_LAN),
      .REG_ADDR(REG_ADDR), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .EE_INIT_CTRL3(EE_INIT_CTRL3),
      .MGMT_PIN_EN(MGMT_PIN_EN), .MGMT_CLK_O(MGMT_CLK_O), .MGMT_CLK_OE(MGMT_CLK_OE),
      .MGMT_DATA_I(dat), .MGMT_DATA_O(MGMT_DATA_O), .MGMT_DATA_OE(MGMT_DATA_OE));
   pmr_phy_model u_phy0 (.clk_lvl(~MGMT_CLK_OE[0]), .dat_lvl(dat[0]), .i2c(i2c[0]),
      .rd_val(rv[0]), .pull(pull[0]));
   pmr_phy_model u_phy1 (.clk_lvl(~MGMT_CLK_OE[1]), .dat_lvl(dat[1]), .i2c(i2c[1]),
      .rd_val(rv[1]), .pull(pull[1]));
   initial forever #10 CLK = ~CLK;
   initial begin
      #3;
      forever #7.5 LINK_CLK = ~LINK_CLK;
   end
   always @(posedge MGMT_CLK_OE[0]) n_act[0]++;
   always @(posedge MGMT_CLK_OE[1]) n_act[1]++;
   task automatic bad(input logic [31:0] g, input logic [31:0] e);
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
   endtask
   task automatic cmp_rd(input logic [63:0] e);
      if (e[63:32] != 32'h0) begin
         n_compared++;
         if ((REG_RDATA & e[63:32]) !== e[31:0]) bad(REG_RDATA & e[63:32], e[31:0]);
      end
   endtask
   task automatic cmp_pin(input logic [1:0] g, input logic [1:0] e);
      n_compared++;
      if (g !== e) bad({30'h0, g}, {30'h0, e});
   endtask
   // Reads leave a {mask, expected} note; the monitor checks it when data returns
   always @(posedge CLK) if (REG_RVALID === 1'b1) cmp_rd(q.pop_front());
   task automatic acc(input logic [1:0] l, input logic [15:0] a, input logic wr,
                      input logic [31:0] d, input logic [31:0] m);
      @(posedge CLK);
      #2;
      REG_LAN = l;
      REG_ADDR = a;
      REG_WE = wr;
      REG_RE = !wr;
      REG_WDATA = d;
      if (!wr) q.push_back({m, d});
      @(posedge CLK);
      #2;
      rd = REG_RDATA;
      REG_WE = 1'b0;
      REG_RE = 1'b0;
   endtask
   task automatic cmd(input logic [1:0] l, input logic tw, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m, input logic [1:0] p);
      int a0, a1, k;
      logic [15:0] a;
      a = tw ? 16'h1028 : 16'h0020;
      a0 = n_act[0];
      a1 = n_act[1];
      acc(l, a, 1'b1, d, 32'h0);
      k = 0;
      do begin
         acc(l, a, 1'b0, 32'h0, 32'h0);
         k++;
      end while (rd[tw ? 29 : 28] !== 1'b1 && k < 12000);
      acc(l, a, 1'b0, e, m);
      cmp_pin({n_act[1] != a1, n_act[0] != a0}, p);
   endtask
   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #1600000;
      err_total++;
      finish_test();
   end
   initial begin
      rv[0] = 16'($random(seed));
      rv[1] = 16'($random(seed));
      w = 16'($random(seed));
      // Two cycles span two link edges, enough for the engines' reset synchroniser
      repeat (2) @(posedge CLK);
      #2;
      SRST = 1'b0;
      repeat (4) @(posedge CLK);
      for (int l = 0; l < 4; l++) acc(2'(l), 16'h0E04, 1'b0, {EE_INIT_CTRL3[16*l+2],
         EE_INIT_CTRL3[16*l+3], 30'h0}, 32'hFFFFFFFF);
      acc(2'h0, 16'h0018, 1'b0, 32'h0, 32'hFFFFFFFF);
      acc(2'h1, 16'h0020, 1'b0, 32'h10000000, 32'hFFFFFFFF);
      acc(2'h2, 16'h1028, 1'b0, 32'h20000000, 32'hFFFFFFFF);
      acc(2'h3, 16'h0100, 1'b0, 32'h0, 32'hFFFFFFFF);
      cmp_pin(MGMT_PIN_EN, 2'h0);
      acc(2'h0, 16'h0018, 1'b1, 32'h02000000, 32'h0);
      acc(2'h1, 16'h0E04, 1'b1, 32'h0, 32'h0);
      acc(2'h1, 16'h0018, 1'b1, 32'h02000000, 32'h0);
      cmp_pin(MGMT_PIN_EN, 2'h1);
      acc(2'h1, 16'h0E04, 1'b1, 32'h80000000, 32'h0);
      cmp_pin(MGMT_PIN_EN, 2'h3);
      cmd(2'h3, 1'b0, 32'h08220000, 32'h50000000, 32'h50000000, 2'h0);
      cmd(2'h0, 1'b0, 32'h08220000, {16'h1000, rv[0]}, 32'h5000FFFF, 2'h1);
      cmd(2'h1, 1'b0, {16'h0422, w}, {16'h1000, w}, 32'h5000FFFF, 2'h2);
      cmd(2'h2, 1'b0, 32'h08220000, {16'h1000, rv[0]}, 32'h5000FFFF, 2'h1);
      cmd(2'h0, 1'b0, 32'h00220000, 32'h50000000, 32'h50000000, 2'h0);
      acc(2'h1, 16'h0E04, 1'b1, 32'hC0000000, 32'h0);
      cmd(2'h1, 1'b0, 32'h08220000, {16'h1000, rv[0]}, 32'h5000FFFF, 2'h1);
      acc(2'h2, 16'h0020, 1'b1, {16'h0422, w}, 32'h0);
      cmd(2'h0, 1'b0, 32'h08220000, {16'h1000, rv[0]}, 32'h5000FFFF, 2'h1);
      acc(2'h2, 16'h0020, 1'b0, {16'h1000, w}, 32'h5000FFFF);
      acc(2'h0, 16'h0E04, 1'b1, 32'h80000000, 32'h0);
      cmd(2'h2, 1'b0, 32'h08220000, 32'h50000000, 32'h50000000, 2'h0);
      cmd(2'h1, 1'b0, 32'h08220000, {16'h1000, rv[1]}, 32'h5000FFFF, 2'h2);
      i2c[0] = 1'b1;
      cmd(2'h0, 1'b1, {16'h0312, w}, {16'h2000, w}, 32'hA000FFFF, 2'h1);
      cmd(2'h0, 1'b1, 32'h0B000000, {16'h2000, rv[0]}, 32'hA000FFFF, 2'h1);
      repeat (2) @(posedge CLK);
      finish_test();
   end
endmodule
